// ### hdl/fwd_pkg.sv
/*
 * Constants, types and helpers for the downstream/upstream frame forwarder of an internal
 * modem card, sitting between the cable-side MAC and the host bus data mover.
 * Assumes byte-wide frame streams with first-byte and last-byte marks.
 */
// Behaviour
// - host unicast frames go to host
// - broadcast frames go to host
// - multicast forwarded only per operator filter
// - host may add further multicast restriction
// - host cannot read or change operator filter
// - while host sleeps, match wake patterns
// - pattern match drives power-management event pin
// - never pass modem-own-address frames to host
// - no local replies to TEST or XID
// - TEST and XID frames reach host unchanged
// - host outbound frames go upstream, filtered
// - all addresses are 48 bits wide
// - plain MAC forwarding, no spanning tree
// - IPv4 payload carried without change
// - length-field and type-field frames both pass
// - connectionless LLC type 1 with SNAP
// - hold modem address and host address
// - other unicast destinations never reach host
// - own-address frames go to modem stack
package fwd_pkg;
   localparam int          ADDR_W      = 48;
   localparam logic [47:0] BCAST_ADDR  = 48'hFFFF_FFFF_FFFF;
   localparam logic [2:0]  HDR_LAST    = 3'h5;
   localparam int          HASH_W      = 6;
   localparam int          HASH_N      = 64;
   localparam logic [10:0] WIN_LEN     = 11'h006;
   localparam int          GROUP_BIT   = 40;

   typedef enum logic [1:0] {
      ST_HDR  = 2'b00,
      ST_EMIT = 2'b01,
      ST_PASS = 2'b10,
      ST_DROP = 2'b11
   } state_type;

   typedef enum logic [1:0] {
      ROUTE_DROP  = 2'b00,
      ROUTE_HOST  = 2'b01,
      ROUTE_MODEM = 2'b10
   } route_type;

   // folds a destination into an index of the multicast filter tables
   function automatic logic [5:0] mcast_hash(input logic [47:0] a);
      logic [5:0] h;
      h = 6'h00;
      for (int i = 0; i < 8; i++) begin
         h = h ^ 6'(a >> (6 * i));
      end
      return h;
   endfunction
endpackage

// ### hdl/modem_host_frame_forwarder.sv
/*
 * Frame forwarder: classifies downstream frames by destination and passes them to the
 * host or the modem stack, watches for wake patterns, and forwards host outbound frames.
 * Assumes synchronous byte streams; filter and address inputs are quasi-static, and the
 * operator filter inputs are driven only by the modem's own provisioning logic.
 */
`timescale 1ns/100ps
`default_nettype none
module modem_host_frame_forwarder (
   // clock, reset, enable
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               ce,
   // addresses
   input  wire logic [47:0]        own_addr,
   input  wire logic [47:0]        host_addr,
   // operator multicast filter (no host path)
   input  wire logic [63:0]        op_mcast_allow,
   // host multicast restriction
   input  wire logic [63:0]        host_mcast_allow,
   // wake pattern set-up
   input  wire logic               host_asleep,
   input  wire logic               wake_enable,
   input  wire logic [47:0]        wake_pattern,
   input  wire logic [5:0]         wake_mask,
   input  wire logic [10:0]        wake_offset,
   // power-management event pin, open drain
   output logic                    pme_out,
   output logic                    pme_oe,
   // downstream from cable MAC
   input  wire logic               ds_valid,
   input  wire logic [7:0]         ds_data,
   input  wire logic               ds_sof,
   input  wire logic               ds_eof,
   output logic                    ds_ready,
   // toward host
   output logic                    host_valid,
   output logic [7:0]              host_data,
   output logic                    host_sof,
   output logic                    host_eof,
   // toward modem stack
   output logic                    modem_valid,
   output logic [7:0]              modem_data,
   output logic                    modem_sof,
   output logic                    modem_eof,
   // outbound from host
   input  wire logic               us_in_valid,
   input  wire logic [7:0]         us_in_data,
   input  wire logic               us_in_sof,
   input  wire logic               us_in_eof,
   input  wire logic               us_enable,
   // toward cable MAC
   output logic                    us_out_valid,
   output logic [7:0]              us_out_data,
   output logic                    us_out_sof,
   output logic                    us_out_eof
);

   fwd_pkg::state_type state;
   fwd_pkg::state_type next_state;
   fwd_pkg::route_type route;
   fwd_pkg::route_type next_route;
   logic [2:0]         cnt;
   logic [2:0]         idx;
   logic               last_q;
   logic [7:0]         hdr [0:5];
   logic [47:0]        dest_now;
   logic [47:0]        dest_q;
   logic               accept;
   logic               out_valid;
   logic [7:0]         out_data;
   logic               out_sof;
   logic               out_eof;
   logic [10:0]        pos;
   logic [10:0]        cur_pos;
   logic [10:0]        rel;
   logic               in_win;
   logic               byte_ok;
   logic [2:0]         win_seen;
   logic               win_miss;
   logic               frame_to_host;

   // classification in fixed order, every address 48 bits wide
   function automatic fwd_pkg::route_type classify(input logic [47:0] d);
      logic [5:0] h;
      h = fwd_pkg::mcast_hash(d);
      if (d == own_addr) begin
         return fwd_pkg::ROUTE_MODEM;
      end else if (d == host_addr) begin
         return fwd_pkg::ROUTE_HOST;
      end else if (d == fwd_pkg::BCAST_ADDR) begin
         return fwd_pkg::ROUTE_HOST;
      end else if (d[fwd_pkg::GROUP_BIT] && op_mcast_allow[h] && host_mcast_allow[h]) begin
         return fwd_pkg::ROUTE_HOST;
      end else begin
         return fwd_pkg::ROUTE_DROP;
      end
   endfunction

   assign accept   = ds_valid && ds_ready;
   assign dest_now = {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], ds_data};
   assign dest_q   = {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]};

   // next state; header is held back so routing is known before the first byte leaves
   always_comb begin
      next_state = state;
      next_route = classify(dest_now);
      case (state)
         fwd_pkg::ST_HDR: begin
            if (accept && (cnt != 3'h0 || ds_sof)) begin
               if (cnt == fwd_pkg::HDR_LAST) begin
                  if (next_route != fwd_pkg::ROUTE_DROP) begin
                     next_state = fwd_pkg::ST_EMIT;
                  end else if (!ds_eof) begin
                     next_state = fwd_pkg::ST_DROP;
                  end
               end
            end
         end
         fwd_pkg::ST_EMIT: begin
            if (idx == fwd_pkg::HDR_LAST) begin
               next_state = last_q ? fwd_pkg::ST_HDR : fwd_pkg::ST_PASS;
            end
         end
         fwd_pkg::ST_PASS, fwd_pkg::ST_DROP: begin
            if (accept && ds_eof) begin
               next_state = fwd_pkg::ST_HDR;
            end
         end
         default: next_state = fwd_pkg::ST_HDR;
      endcase
   end

   // state, route and the stall toward the cable side during header replay
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state    <= fwd_pkg::ST_HDR;
         route    <= fwd_pkg::ROUTE_DROP;
         ds_ready <= 1'b1;
      end else if (ce) begin
         state    <= next_state;
         ds_ready <= (next_state != fwd_pkg::ST_EMIT);
         if (state == fwd_pkg::ST_HDR && accept && cnt == fwd_pkg::HDR_LAST) begin
            route <= next_route;
         end
      end
   end

   // header byte counter; runt frames under six bytes are discarded
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt    <= 3'h0;
         last_q <= 1'b0;
      end else if (ce) begin
         if (state == fwd_pkg::ST_HDR && accept && (cnt != 3'h0 || ds_sof)) begin
            if (cnt == fwd_pkg::HDR_LAST || ds_eof) begin
               cnt <= 3'h0;
            end else begin
               cnt <= cnt + 3'h1;
            end
            last_q <= ds_eof;
         end
      end
   end

   // header store, one byte register per destination octet
   for (genvar g = 0; g < 6; g++) begin : g_hdr
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            hdr[g] <= 8'h00;
         end else if (ce) begin
            if (state == fwd_pkg::ST_HDR && accept && cnt == 3'(g) && (g != 0 || ds_sof)) begin
               hdr[g] <= ds_data;
            end
         end
      end
   end

   // replay index over the held header
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idx <= 3'h0;
      end else if (ce) begin
         if (state == fwd_pkg::ST_EMIT) begin
            idx <= idx + 3'h1;
         end else begin
            idx <= 3'h0;
         end
      end
   end

   // byte that leaves this cycle; payload is never touched, so LLC, SNAP and IP pass as is
   always_comb begin
      out_valid = 1'b0;
      out_data  = ds_data;
      out_sof   = 1'b0;
      out_eof   = 1'b0;
      if (state == fwd_pkg::ST_EMIT) begin
         out_valid = 1'b1;
         out_data  = hdr[idx];
         out_sof   = (idx == 3'h0);
         out_eof   = (idx == fwd_pkg::HDR_LAST) && last_q;
      end else if (state == fwd_pkg::ST_PASS && accept) begin
         out_valid = 1'b1;
         out_eof   = ds_eof;
      end
   end

   // output registers steered by the stored route
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         host_valid  <= 1'b0;
         host_data   <= 8'h00;
         host_sof    <= 1'b0;
         host_eof    <= 1'b0;
         modem_valid <= 1'b0;
         modem_data  <= 8'h00;
         modem_sof   <= 1'b0;
         modem_eof   <= 1'b0;
      end else if (ce) begin
         host_valid  <= out_valid && (route == fwd_pkg::ROUTE_HOST);
         host_data   <= out_data;
         host_sof    <= out_sof;
         host_eof    <= out_eof;
         modem_valid <= out_valid && (route == fwd_pkg::ROUTE_MODEM);
         modem_data  <= out_data;
         modem_sof   <= out_sof;
         modem_eof   <= out_eof;
      end
   end

   // wake window: six masked bytes starting at a programmed frame offset
   // a frame start is byte 0 whatever pos still holds from the last frame
   assign cur_pos = (state == fwd_pkg::ST_HDR && ds_sof) ? 11'h000 : pos;
   assign rel     = cur_pos - wake_offset;
   assign in_win  = (cur_pos >= wake_offset) && (rel < fwd_pkg::WIN_LEN);
   assign byte_ok = !wake_mask[3'(rel)] ||
                    (ds_data == 8'(wake_pattern >> (8 * (5 - int'(rel[2:0])))));
   assign frame_to_host = (state == fwd_pkg::ST_HDR) ? (next_route == fwd_pkg::ROUTE_HOST)
                                                     : (route == fwd_pkg::ROUTE_HOST);

   // byte position and window progress, restarted at every frame start
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pos      <= 11'h000;
         win_seen <= 3'h0;
         win_miss <= 1'b0;
      end else if (ce) begin
         if (accept && ds_sof && state == fwd_pkg::ST_HDR) begin
            pos      <= 11'h001;
            win_seen <= (wake_offset == 11'h000) ? 3'h1 : 3'h0;
            win_miss <= (wake_offset == 11'h000) && !byte_ok;
         end else if (accept && pos != 11'h7FF) begin
            pos <= pos + 11'h001;
            if (in_win) begin
               win_seen <= win_seen + 3'h1;
               win_miss <= win_miss || !byte_ok;
            end
         end
      end
   end

   // event pin: held low while asleep after a hit, released once the host wakes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pme_out <= 1'b0;
         pme_oe  <= 1'b0;
      end else if (ce) begin
         pme_out <= 1'b0;
         if (!host_asleep) begin
            pme_oe <= 1'b0;
         end else if (wake_enable && accept && ds_eof && frame_to_host && !(in_win && !byte_ok)
                      && !win_miss && (win_seen + 3'(in_win)) == 3'h6) begin
            pme_oe <= 1'b1;
         end
      end
   end

   // outbound path, one register stage, gated by the modem's upstream filter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         us_out_valid <= 1'b0;
         us_out_data  <= 8'h00;
         us_out_sof   <= 1'b0;
         us_out_eof   <= 1'b0;
      end else if (ce) begin
         us_out_valid <= us_in_valid && us_enable;
         us_out_data  <= us_in_data;
         us_out_sof   <= us_in_sof;
         us_out_eof   <= us_in_eof;
      end
   end

   // checks
   own_block_a: assert property (
      @(posedge mclk) disable iff (rst) host_valid && host_sof |-> dest_q != own_addr)
      else $error("own-address frame reached host");

   modem_route_a: assert property (
      @(posedge mclk) disable iff (rst) modem_valid && modem_sof |-> dest_q == own_addr)
      else $error("non-own frame sent to modem stack");

   host_unicast_a: assert property (
      @(posedge mclk) disable iff (rst)
      host_valid && host_sof |-> dest_q == host_addr || dest_q[fwd_pkg::GROUP_BIT])
      else $error("foreign unicast reached host");

   bcast_route_a: assert property (
      @(posedge mclk) disable iff (rst)
      ce && state == fwd_pkg::ST_HDR && accept && cnt == fwd_pkg::HDR_LAST
      && dest_now == fwd_pkg::BCAST_ADDR && own_addr != fwd_pkg::BCAST_ADDR
      |=> route == fwd_pkg::ROUTE_HOST && state == fwd_pkg::ST_EMIT)
      else $error("broadcast not routed to host");

   mcast_filter_a: assert property (
      @(posedge mclk) disable iff (rst)
      host_valid && host_sof && dest_q[fwd_pkg::GROUP_BIT] && dest_q != fwd_pkg::BCAST_ADDR
      && dest_q != own_addr && dest_q != host_addr
      |-> op_mcast_allow[fwd_pkg::mcast_hash(dest_q)] && host_mcast_allow[fwd_pkg::mcast_hash(dest_q)])
      else $error("filtered multicast reached host");

   replay_stall_a: assert property (
      @(posedge mclk) disable iff (rst)
      ce && state == fwd_pkg::ST_HDR && next_state == fwd_pkg::ST_EMIT
      |=> !ds_ready [*6])
      else $error("header replay not stalled for six cycles");

   payload_pass_a: assert property (
      @(posedge mclk) disable iff (rst)
      ce && state == fwd_pkg::ST_PASS && accept && route == fwd_pkg::ROUTE_HOST
      |=> host_valid && host_data == $past(ds_data) && host_eof == $past(ds_eof))
      else $error("payload byte altered or lost");

   pme_cause_a: assert property (
      @(posedge mclk) disable iff (rst) $rose(pme_oe) |-> $past(host_asleep) && $past(wake_enable))
      else $error("event pin raised without sleeping host");

   pme_release_a: assert property (
      @(posedge mclk) disable iff (rst) ce && !host_asleep |=> !pme_oe && !pme_out)
      else $error("event pin held while host awake");

   upstream_fwd_a: assert property (
      @(posedge mclk) disable iff (rst)
      ce && us_in_valid && us_enable |=> us_out_valid && us_out_data == $past(us_in_data))
      else $error("outbound byte not forwarded");

endmodule // modem_host_frame_forwarder
`default_nettype wire

// ### sim/stream_sink_model.sv
/*
 * byte-stream sink standing for the host receive path or the modem stack.
 * assumes one byte per cycle and no back-pressure from this side.
 */
`timescale 1ns/100ps
`default_nettype none
module stream_sink_model (
   // clock and clear
   input  wire logic       mclk,
   input  wire logic       clr,
   // incoming stream
   input  wire logic       valid,
   input  wire logic [7:0] data,
   input  wire logic       sof,
   input  wire logic       eof,
   // capture counts
   output var int          nbytes,
   output var int          nframes,
   output var int          nbad
);
   logic [7:0] mem [0:63];
   // the host never stalls the card, so every valid byte is kept
   always @(posedge mclk) begin
      if (clr) begin
         nbytes <= 0;
         nframes <= 0;
         nbad <= 0;
      end else if (valid) begin
         mem[nbytes[5:0]] <= data;
         nbytes <= nbytes + 1;
         if (sof != (nbytes == 0)) nbad <= nbad + 1; // sof only on first byte
         if (eof) nframes <= nframes + 1;
      end
   end
endmodule // stream_sink_model
`default_nettype wire

// ### sim/tb_modem_host_frame_forwarder.sv
/*
 * testbench for the frame forwarder: frame routing, multicast tables, wake pin, upstream.
 * assumes the forwarder of hdl/ and the stream sink model of sim/.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_modem_host_frame_forwarder;
   logic        mclk, rst, ce, clr, host_asleep, wake_enable, pme_out, pme_oe;
   logic [47:0] own_addr, host_addr, wake_pattern;
   logic [63:0] op_mcast_allow, host_mcast_allow;
   logic [5:0]  wake_mask;
   logic [10:0] wake_offset;
   logic        ds_valid, ds_sof, ds_eof, ds_ready, host_valid, host_sof, host_eof;
   logic        modem_valid, modem_sof, modem_eof, us_in_valid, us_in_sof, us_in_eof;
   logic        us_enable, us_out_valid, us_out_sof, us_out_eof;
   logic [7:0]  ds_data, host_data, modem_data, us_in_data, us_out_data;
   logic [7:0]  frm [0:19];
   int          err_total, cmp_count;

   modem_host_frame_forwarder u_modem_host_frame_forwarder (
      .mclk(mclk), .rst(rst), .ce(ce), .own_addr(own_addr), .host_addr(host_addr),
      .op_mcast_allow(op_mcast_allow), .host_mcast_allow(host_mcast_allow),
      .host_asleep(host_asleep), .wake_enable(wake_enable), .wake_pattern(wake_pattern),
      .wake_mask(wake_mask), .wake_offset(wake_offset), .pme_out(pme_out), .pme_oe(pme_oe),
      .ds_valid(ds_valid), .ds_data(ds_data), .ds_sof(ds_sof), .ds_eof(ds_eof),
      .ds_ready(ds_ready), .host_valid(host_valid), .host_data(host_data),
      .host_sof(host_sof), .host_eof(host_eof), .modem_valid(modem_valid),
      .modem_data(modem_data), .modem_sof(modem_sof), .modem_eof(modem_eof),
      .us_in_valid(us_in_valid), .us_in_data(us_in_data), .us_in_sof(us_in_sof),
      .us_in_eof(us_in_eof), .us_enable(us_enable), .us_out_valid(us_out_valid),
      .us_out_data(us_out_data), .us_out_sof(us_out_sof), .us_out_eof(us_out_eof));
   stream_sink_model u_host_sink (.mclk(mclk), .clr(clr), .valid(host_valid),
      .data(host_data), .sof(host_sof), .eof(host_eof),
      .nbytes(), .nframes(), .nbad());
   stream_sink_model u_modem_sink (.mclk(mclk), .clr(clr), .valid(modem_valid),
      .data(modem_data), .sof(modem_sof), .eof(modem_eof),
      .nbytes(), .nframes(), .nbad());

   // compare with four-state equality so an unknown matches only an unknown
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // own copy of the table index, kept apart from the design's helper
   function automatic logic [5:0] idx6(input logic [47:0] a);
      logic [5:0] h;
      h = 6'h00;
      for (int i = 0; i < 8; i++) h = h ^ a[6*i +: 6];
      return h;
   endfunction

   task automatic mk(input logic [47:0] d);
      for (int i = 0; i < 20; i++) frm[i] = 8'(8'h30 + i);
      for (int i = 0; i < 6; i++) frm[i] = d[47-8*i -: 8];
      frm[12] = 8'h08;
      frm[13] = 8'h00;
   endtask

   // a byte is offered only while ds_ready is seen high at the falling edge
   task automatic send(input int n);
      int w;
      for (int k = 0; k < n; k++) begin
         w = 0;
         @(negedge mclk);
         while (ds_ready !== 1'b1 && w < 50) begin
            ds_valid = 1'b0;
            w++;
            @(negedge mclk);
         end
         if (w >= 50) begin
            err_total++;
            end_sim();
         end
         ds_valid = 1'b1;
         ds_data = frm[k];
         ds_sof = (k == 0);
         ds_eof = (k == n - 1);
      end
      @(negedge mclk);
      ds_valid = 1'b0;
   endtask

   task automatic run(input string what, input int n, input int eh, input int em);
      @(negedge mclk);
      clr = 1'b1;
      @(negedge mclk);
      clr = 1'b0;
      send(n);
      repeat (20) @(negedge mclk);
      chk({what, " host frames"}, 64'(u_host_sink.nframes), 64'(eh));
      chk({what, " host bytes"}, 64'(u_host_sink.nbytes), 64'(eh * n));
      chk({what, " modem frames"}, 64'(u_modem_sink.nframes), 64'(em));
      chk({what, " sof marks"}, 64'(u_host_sink.nbad), 64'h0);
      chk({what, " modem bytes"}, 64'(u_modem_sink.nbytes), 64'(em * n));
      chk({what, " modem sof marks"}, 64'(u_modem_sink.nbad), 64'h0);
      if (em == 1) begin
         for (int i = 0; i < n; i++) chk({what, " modem byte"}, 64'(u_modem_sink.mem[i]), 64'(frm[i]));
      end
      if (eh == 1) begin
         for (int i = 0; i < n; i++) chk({what, " byte"}, 64'(u_host_sink.mem[i]), 64'(frm[i]));
      end
   endtask

   task automatic t_routes;
      mk(host_addr);
      frm[12] = 8'h00; // length-field frame carrying an LLC test request
      frm[13] = 8'h03;
      frm[16] = 8'hE3; // test-type control byte is passed, not answered
      run("unicast", 20, 1, 0);
      mk(fwd_pkg::BCAST_ADDR);
      run("broadcast", 20, 1, 0);
      mk(own_addr);
      run("own", 20, 0, 1);
      mk(48'h02AA_0000_0003);
      run("other", 20, 0, 0);
   endtask

   task automatic t_mcast;
      logic [47:0] g;
      g = 48'h0100_5E00_0001;
      op_mcast_allow = 64'h1 << idx6(g);
      host_mcast_allow = op_mcast_allow;
      mk(g);
      run("mcast allowed", 20, 1, 0);
      host_mcast_allow = 64'h0;
      run("mcast host deny", 20, 0, 0);
      op_mcast_allow = 64'h0;
      host_mcast_allow = 64'hFFFF_FFFF_FFFF_FFFF;
      run("mcast op deny", 20, 0, 0);
   endtask

   task automatic t_wake;
      host_asleep = 1'b1;
      wake_enable = 1'b1;
      wake_offset = 11'h00C;
      wake_mask = 6'h0F;
      mk(host_addr);
      wake_pattern = {8'h77, frm[13], frm[14], frm[15], 16'hAAAA};
      run("wake miss", 20, 1, 0);
      chk("pme miss", 64'(pme_oe), 64'h0);
      wake_pattern = {frm[12], frm[13], frm[14], frm[15], 16'hAAAA}; // masked-out bytes differ
      run("wake hit", 20, 1, 0);
      chk("pme hit", 64'(pme_oe), 64'h1);
      chk("pme data", 64'(pme_out), 64'h0);
      @(negedge mclk);
      host_asleep = 1'b0;
      repeat (2) @(negedge mclk);
      chk("pme clear", 64'(pme_oe), 64'h0);
      run("wake awake", 20, 1, 0);
      chk("pme awake", 64'(pme_oe), 64'h0);
      // window at the very first byte: destination itself is the pattern
      host_asleep = 1'b1;
      wake_offset = 11'h000;
      wake_mask = 6'h3F;
      wake_pattern = host_addr;
      run("wake at start", 20, 1, 0);
      chk("pme at start", 64'(pme_oe), 64'h1);
      host_asleep = 1'b0;
   endtask

   task automatic t_up;
      for (int e = 0; e < 2; e++) begin
         us_enable = 1'(e);
         @(negedge mclk);
         us_in_valid = 1'b1;
         us_in_data = 8'(8'hC4 + e);
         us_in_sof = 1'b1;
         us_in_eof = 1'b1;
         @(negedge mclk);
         us_in_valid = 1'b0;
         chk("up valid", 64'(us_out_valid), 64'(e));
         chk("up data", 64'(us_out_data), 64'(8'hC4 + e));
         chk("up marks", 64'({us_out_sof, us_out_eof}), 64'h3);
      end
      // clock enable low: the outbound stage must hold its last contents
      @(negedge mclk);
      ce = 1'b0;
      us_in_valid = 1'b1;
      us_in_data = 8'h5A;
      @(negedge mclk);
      chk("up frozen valid", 64'(us_out_valid), 64'h0);
      chk("up frozen data", 64'(us_out_data), 64'hC5);
      ce = 1'b1;
      us_in_valid = 1'b0;
   endtask

   // free-running bench clock, 100 ns period
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial begin
      rst = 1'b1; ce = 1'b1; clr = 1'b1; host_asleep = 1'b0; wake_enable = 1'b0;
      own_addr = 48'h02AA_0000_0001; host_addr = 48'h02AA_0000_0002;
      op_mcast_allow = 64'h0; host_mcast_allow = 64'h0; wake_pattern = 48'h0;
      wake_mask = 6'h00; wake_offset = 11'h000; ds_valid = 1'b0; ds_data = 8'h00;
      ds_sof = 1'b0; ds_eof = 1'b0; us_in_valid = 1'b0; us_in_data = 8'h00;
      us_in_sof = 1'b0; us_in_eof = 1'b0; us_enable = 1'b0;
      err_total = 0; cmp_count = 0;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      t_routes();
      t_mcast();
      t_wake();
      t_up();
      end_sim();
   end
endmodule // tb_modem_host_frame_forwarder
`default_nettype wire
